/* common/dpctl_pkg.sv */
/*
  Constants and types for the dual-port memory port controller.
  Assumes a 25 MHz aclk and one port of an asynchronous dual-port memory.
*/
// Overview of operation
// RULE1 - Address changes only while strobe or select high
// RULE2 - Write happens during select and strobe overlap
// RULE3 - Select after strobe keeps outputs tristated
// RULE4 - Memory or flag select, never both
// RULE5 - Flag read drives all sixteen lines
// RULE6 - Simultaneous flag claims grant one side
// RULE7 - Earlier stable port wins in primary
// RULE8 - Secondary mode performs no arbitration
// RULE9 - Too-close match stalls exactly one port
// RULE10 - Low stall input blocks write until high
// RULE11 - Loser holds strobe write-hold after stall release
// RULE12 - Stall asserted after match within access delay
// RULE13 - Eight flags, bit zero written, state read
// RULE14 - Free flag reads one; zero write claims
// RULE15 - Pending claim passes on owner release
// RULE16 - Requester gains nothing; release frees flag
// RULE17 - Stall high when no match or deselected; secondary-role model pulls stall_n low on other_hit even if deselected
// RULE18 - Role pin selects primary or secondary
// RULE19 - Never both stall outputs low
// RULE20 - Writes ignored while own stall low
// RULE21 - Arbitration uses selects and addresses only
// RULE22 - Ties resolved by fixed documented tie-break
package dpctl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADDR_SETUP_NS = 15;
  localparam int unsigned STROBE_NS = 25;
  localparam int unsigned WRITE_HOLD_NS = 25;
  localparam int unsigned ACCESS_NS = 55;
  localparam int unsigned SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC = (WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] RDATA_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_WR_BIT = 1;
  localparam int unsigned CTRL_FLAG_BIT = 2;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_STALLED_BIT = 1;
  localparam int unsigned STAT_ROLE_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT, ST_HOLD, ST_DONE} dpctl_state_t;
endpackage : dpctl_pkg

/* hdl/dpctl_port_ctrl.sv */
/*
  Host-side controller for one port of an asynchronous dual-port memory.
  Software orders single memory or lock-flag accesses over AXI4-Lite;
  the memory pins are driven from flip-flops, the byte enables from an AND of the two select flip-flops. Memory pins are assumed
  asynchronous, so stall and read data pass two flip-flops.
*/
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module dpctl_port_ctrl #(
  parameter int AW = 14,
  parameter int DW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [AW-1:0] mem_addr,
  output logic chip_select_n,
  output logic flag_select_n,
  output logic write_strobe_n,
  output logic output_enable_n,
  output logic upper_byte_enable_n,
  output logic lower_byte_enable_n,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  input wire logic stall_n,
  input wire logic primary_role
);
  dpctl_pkg::dpctl_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic cs_q, cs_d, fs_q, fs_d, we_q, we_d, oe_q, oe_d, doe_q, doe_d;
  logic stalled_q, stalled_d;
  logic [1:0] stall_sync_q;
  logic [DW-1:0] din_s1_q, din_s2_q;
  logic aw_seen_q, aw_seen_d, w_seen_q, w_seen_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic stall_s, go, is_wr;

  // Two-stage sync; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_sync_q <= 2'h3;
      din_s1_q <= '0;
      din_s2_q <= '0;
    end else begin
      stall_sync_q <= {stall_sync_q[0], stall_n};
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end
  assign stall_s = ~stall_sync_q[1];

  // Register bus
  assign s_axi_awready = !aw_seen_q && !bv_q;
  assign s_axi_wready = !w_seen_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  always_comb begin
    logic aw_now, w_now;
    aw_now = aw_seen_q || (s_axi_awvalid && s_axi_awready);
    w_now = w_seen_q || (s_axi_wvalid && s_axi_wready);
    aw_seen_d = aw_seen_q;
    w_seen_d = w_seen_q;
    awa_d = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awa_q;
    wd_d = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wd_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    go = 1'b0;
    if (s_axi_awvalid && s_axi_awready) aw_seen_d = 1'b1;
    if (s_axi_wvalid && s_axi_wready) w_seen_d = 1'b1;
    if (aw_now && w_now && !bv_q) begin
      logic [7:0] a;
      logic [31:0] d;
      a = aw_seen_q ? awa_q : s_axi_awaddr;
      d = w_seen_q ? wd_q : s_axi_wdata;
      aw_seen_d = 1'b0;
      w_seen_d = 1'b0;
      bv_d = 1'b1;
      br_d = dpctl_pkg::RESP_OKAY;
      case (a)
        dpctl_pkg::CTRL_OFS: begin
          ctrl_d = d;
          // New orders are dropped while a port cycle runs
          go = d[dpctl_pkg::CTRL_GO_BIT] && (st_q == dpctl_pkg::ST_IDLE);
        end
        dpctl_pkg::ADDR_OFS: addr_d = d[AW-1:0];
        dpctl_pkg::WDATA_OFS: wdata_d = d[DW-1:0];
        dpctl_pkg::RDATA_OFS, dpctl_pkg::STAT_OFS: br_d = dpctl_pkg::RESP_OKAY;
        default: br_d = dpctl_pkg::RESP_SLVERR;
      endcase
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rr_d = dpctl_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dpctl_pkg::CTRL_OFS: rd_d = ctrl_q;
        dpctl_pkg::ADDR_OFS: rd_d = {{(32-AW){1'b0}}, addr_q};
        dpctl_pkg::WDATA_OFS: rd_d = {{(32-DW){1'b0}}, wdata_q};
        dpctl_pkg::RDATA_OFS: rd_d = {{(32-DW){1'b0}}, rdata_q};
        dpctl_pkg::STAT_OFS: rd_d = {29'h0, primary_role, stalled_q, st_q != dpctl_pkg::ST_IDLE};
        default: begin
          rd_d = 32'h0000_0000;
          rr_d = dpctl_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_seen_q <= 1'b0;
      w_seen_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      bv_q <= 1'b0;
      br_q <= 2'h0;
      rv_q <= 1'b0;
      rr_q <= 2'h0;
      rd_q <= 32'h0000_0000;
      ctrl_q <= dpctl_pkg::CTRL_RESET;
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      aw_seen_q <= aw_seen_d;
      w_seen_q <= w_seen_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  // Port cycle sequencer
  assign is_wr = ctrl_q[dpctl_pkg::CTRL_WR_BIT];
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cs_d = cs_q;
    fs_d = fs_q;
    we_d = we_q;
    oe_d = oe_q;
    doe_d = doe_q;
    stalled_d = stalled_q;
    rdata_d = rdata_q;
    case (st_q)
      dpctl_pkg::ST_IDLE: begin
        cs_d = 1'b1;
        fs_d = 1'b1;
        we_d = 1'b1;
        oe_d = 1'b1;
        doe_d = 1'b0;
        if (go) begin
          // Exactly one of the two selects goes low
          fs_d = !ctrl_d[dpctl_pkg::CTRL_FLAG_BIT]; // RULE4
          cs_d = ctrl_d[dpctl_pkg::CTRL_FLAG_BIT]; // RULE4
          stalled_d = 1'b0;
          cnt_d = 8'(dpctl_pkg::SETUP_CYC);
          st_d = dpctl_pkg::ST_SETUP;
        end
      end
      dpctl_pkg::ST_SETUP: begin
        // Stall must settle before the strobe falls
        if (cnt_q != dpctl_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          we_d = !is_wr; // RULE2
          oe_d = is_wr;
          doe_d = is_wr;
          cnt_d = 8'(dpctl_pkg::STROBE_CYC);
          st_d = dpctl_pkg::ST_STROBE;
        end
      end
      dpctl_pkg::ST_STROBE: begin
        if (stall_s && is_wr) begin
          stalled_d = 1'b1;
          st_d = dpctl_pkg::ST_WAIT; // RULE10
        end else if (cnt_q != dpctl_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          rdata_d = din_s2_q;
          cnt_d = 8'(dpctl_pkg::ACCESS_CYC);
          st_d = dpctl_pkg::ST_DONE;
        end
      end
      dpctl_pkg::ST_WAIT: begin
        // Strobe kept low; write completes after stall release
        if (!stall_s) begin
          cnt_d = 8'(dpctl_pkg::HOLD_CYC);
          st_d = dpctl_pkg::ST_HOLD; // RULE11
        end
      end
      dpctl_pkg::ST_HOLD: begin
        if (stall_s) begin
          st_d = dpctl_pkg::ST_WAIT;
        end else if (cnt_q != dpctl_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - 8'h01; // RULE11
        end else begin
          cnt_d = dpctl_pkg::CNT_ZERO;
          st_d = dpctl_pkg::ST_DONE;
        end
      end
      dpctl_pkg::ST_DONE: begin
        // Strobe and selects rise in the same cycle; address held until then
        we_d = 1'b1; // RULE1
        oe_d = 1'b1;
        if (!is_wr && cnt_q == 8'(dpctl_pkg::ACCESS_CYC)) rdata_d = din_s2_q;
        cs_d = 1'b1;
        fs_d = 1'b1;
        doe_d = 1'b0;
        st_d = dpctl_pkg::ST_IDLE;
      end
      default: st_d = dpctl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= dpctl_pkg::ST_IDLE;
      cnt_q <= dpctl_pkg::CNT_ZERO;
      cs_q <= 1'b1;
      fs_q <= 1'b1;
      we_q <= 1'b1;
      oe_q <= 1'b1;
      doe_q <= 1'b0;
      stalled_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cs_q <= cs_d;
      fs_q <= fs_d;
      we_q <= we_d;
      oe_q <= oe_d;
      doe_q <= doe_d;
      stalled_q <= stalled_d;
      rdata_q <= rdata_d;
    end
  end

  assign chip_select_n = cs_q;
  assign flag_select_n = fs_q;
  assign write_strobe_n = we_q;
  assign output_enable_n = oe_q;
  assign upper_byte_enable_n = cs_q & fs_q;
  assign lower_byte_enable_n = cs_q & fs_q;
  assign mem_addr = addr_q;
  // Flag writes use bit zero only
  assign data_out = wdata_q;
  assign data_oe = doe_q;

  property p_one_select;
    @(posedge aclk) disable iff (!aresetn)
      !(chip_select_n == 1'b0 && flag_select_n == 1'b0);
  endproperty
  a_one_select: assert property (p_one_select) else $error("both selects low"); // RULE4
  // A read keeps the write window shut and the data lines released
  property p_read_no_drive;
    @(posedge aclk) disable iff (!aresetn)
      !output_enable_n |-> (write_strobe_n && !data_oe);
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) else $error("drive during read"); // RULE2
  property p_addr_stable;
    @(posedge aclk) disable iff (!aresetn)
      (!write_strobe_n && (!chip_select_n || !flag_select_n)) |=> $stable(mem_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in write"); // RULE1
  property p_stall_blocks;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dpctl_pkg::ST_WAIT) |-> !write_strobe_n;
  endproperty
  a_stall_blocks: assert property (p_stall_blocks) else $error("strobe released in stall"); // RULE10
  property p_hold_len;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == dpctl_pkg::ST_WAIT && !stall_s) |=> !write_strobe_n [*2];
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("write hold too short"); // RULE11
  property p_strobe_in_select;
    @(posedge aclk) disable iff (!aresetn)
      !write_strobe_n |-> (!chip_select_n || !flag_select_n);
  endproperty
  a_strobe_in_select: assert property (p_strobe_in_select) else $error("strobe without select"); // RULE2
  c_mem_write: cover property (@(posedge aclk) disable iff (!aresetn)
    !chip_select_n && !write_strobe_n);
  c_flag_write: cover property (@(posedge aclk) disable iff (!aresetn)
    !flag_select_n && !write_strobe_n);
  c_stalled: cover property (@(posedge aclk) disable iff (!aresetn)
    st_q == dpctl_pkg::ST_WAIT ##1 st_q == dpctl_pkg::ST_HOLD);
endmodule : dpctl_port_ctrl

/* testbench/dpctl_mem_model.sv */
/*
  Behavioural model of one port of the dual-port memory and its lock flags.
  Assumes the far port acts only through other_hit and other_flag calls.
*/
`timescale 1ns/1ns
module dpctl_mem_model (
  input wire logic [13:0] mem_addr,
  input wire logic chip_select_n,
  input wire logic flag_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  input wire logic primary_role,
  input wire logic other_hit,
  output logic [15:0] data_in,
  output logic stall_n
);
  logic [15:0] mem [0:16383];
  logic [15:0] dq, wd, rd;
  logic [13:0] wa;
  logic [1:0] be;
  logic [1:0] own [0:7] = '{default: 2'h0};
  logic [1:0] pend [0:7] = '{default: 2'h0};
  logic fw, mw;
  assign dq = data_oe ? data_out : 16'hzzzz;
  // Far port already holds the match, so it wins
  assign stall_n = primary_role ? !(other_hit && !chip_select_n)
                                : !other_hit;
  assign rd = !chip_select_n ? mem[mem_addr] : {16{own[mem_addr[2:0]] != 2'h1}};
  assign data_in = (!output_enable_n && write_strobe_n) ? rd : ~rd;
  // Latch only while the controller drives, so the release edge cannot race
  always @(*) if (!write_strobe_n && data_oe) wd = dq;
  always @(negedge write_strobe_n) begin
    fw = !flag_select_n && chip_select_n;
    mw = !chip_select_n && flag_select_n;
    wa = mem_addr;
    be = {upper_byte_enable_n, lower_byte_enable_n};
  end
  always @(posedge write_strobe_n) begin
    if (mw && stall_n) begin
      if (!be[0]) mem[wa][7:0] = wd[7:0];
      if (!be[1]) mem[wa][15:8] = wd[15:8];
    end
    if (fw) flag_wr(1'h0, wa[2:0], wd[0]);
    fw = 1'h0;
    mw = 1'h0;
  end
  // Calls run one at a time, so the first caller wins a tie
  task flag_wr(input logic s, input logic [2:0] i, input logic v);
    logic [1:0] me;
    me = s ? 2'h2 : 2'h1;
    if (!v) begin
      if (own[i] == 2'h0) own[i] = me;
      else if (own[i] != me) pend[i][s] = 1'h1;
    end else if (own[i] == me) begin
      own[i] = pend[i][!s] ? (s ? 2'h1 : 2'h2) : 2'h0;
      pend[i] = 2'h0;
    end else begin
      pend[i][s] = 1'h0;
    end
  endtask : flag_wr
  task other_flag(input logic [2:0] i, input logic v);
    flag_wr(1'h1, i, v);
  endtask : other_flag
endmodule : dpctl_mem_model

/* testbench/dpctl_port_ctrl_bench.sv */
/*
  Self-checking bench for the port controller against the memory model.
  Assumes the register map and timing of the controller package.
*/
`timescale 1ns/1ns
module dpctl_port_ctrl_bench;
  typedef struct packed {logic fl; logic wr; logic [13:0] a; logic [15:0] d; logic [15:0] e;}
    dpctl_row_t;
  dpctl_row_t rows [0:8] = '{{1'h0, 1'h1, 14'h0005, 16'ha5c3, 16'h0000},
    {1'h0, 1'h0, 14'h0005, 16'h0000, 16'ha5c3}, {1'h0, 1'h1, 14'h3fff, 16'h1234, 16'h0000},
    {1'h0, 1'h0, 14'h3fff, 16'h0000, 16'h1234}, {1'h1, 1'h0, 14'h0003, 16'h0000, 16'hffff},
    {1'h1, 1'h1, 14'h0003, 16'hfffe, 16'h0000}, {1'h1, 1'h0, 14'h0003, 16'h0000, 16'h0000},
    {1'h1, 1'h1, 14'h0003, 16'h0001, 16'h0000}, {1'h1, 1'h0, 14'h0003, 16'h0000, 16'hffff}};
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic primary_role = 1'h1, other_hit = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, data_oe;
  logic chip_select_n, flag_select_n, write_strobe_n, output_enable_n, stall_n;
  logic upper_byte_enable_n, lower_byte_enable_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [13:0] mem_addr, la;
  logic [15:0] data_in, data_out;
  int error_cnt = 0, n_checks = 0, cyc;
  dpctl_port_ctrl dut_u (.*);
  dpctl_mem_model mem_u (.*);
  initial forever #20 aclk = ~aclk;
  initial begin
    #2000000;
    error_cnt++;
    stop_test();
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axi_rd
  task op(input logic fl, input logic wr, input logic [13:0] a, input logic [15:0] d);
    axi_wr(dpctl_pkg::ADDR_OFS, 32'(a));
    axi_wr(dpctl_pkg::WDATA_OFS, 32'(d));
    axi_wr(dpctl_pkg::CTRL_OFS, 32'h1 | 32'(wr) << dpctl_pkg::CTRL_WR_BIT
      | 32'(fl) << dpctl_pkg::CTRL_FLAG_BIT);
    do axi_rd(dpctl_pkg::STAT_OFS); while (rv[dpctl_pkg::STAT_BUSY_BIT]);
    if (!wr) axi_rd(dpctl_pkg::RDATA_OFS);
  endtask : op
  // Address may only move while the memory write window (write strobe and chip select both low) is shut
  always @(posedge aclk) begin
    if (aresetn) chk("one select", 32'h1, 32'(chip_select_n | flag_select_n));
    if (aresetn && !write_strobe_n && !chip_select_n) chk("stable addr", 32'(la), 32'(mem_addr));
    la <= mem_addr;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("idle pins", 32'h7, {29'h0, chip_select_n, flag_select_n, write_strobe_n});
    foreach (rows[k]) begin
      op(rows[k].fl, rows[k].wr, rows[k].a, rows[k].d);
      if (!rows[k].wr) chk("read data", 32'(rows[k].e), 32'(rv[15:0]));
    end
    mem_u.other_flag(3'h5, 1'h0);
    op(1'h1, 1'h1, 14'h0005, 16'h0000);
    op(1'h1, 1'h0, 14'h0005, 16'h0000);
    chk("flag held far", 32'hffff, 32'(rv[15:0]));
    mem_u.other_flag(3'h5, 1'h1);
    op(1'h1, 1'h0, 14'h0005, 16'h0000);
    chk("flag passed", 32'h0, 32'(rv[15:0]));
    op(1'h1, 1'h1, 14'h0005, 16'h0001);
    op(1'h1, 1'h0, 14'h0005, 16'h0000);
    chk("flag freed", 32'hffff, 32'(rv[15:0]));
    for (int m = 0; m < 2; m++) begin
      primary_role <= m[0];
      other_hit <= 1'h1;
      fork
        op(1'h0, 1'h1, 14'h0100 + 14'(m), 16'h5a5a + 16'(m));
        begin
          wait (!write_strobe_n);
          repeat (8) @(posedge aclk);
          chk("strobe held", 32'h0, 32'(write_strobe_n));
          other_hit <= 1'h0;
          cyc = 0;
          while (!write_strobe_n) begin
            @(posedge aclk);
            cyc++;
          end
          chk("hold after stall", 32'h1, 32'(cyc >= dpctl_pkg::HOLD_CYC));
        end
      join
      op(1'h0, 1'h0, 14'h0100 + 14'(m), 16'h0000);
      chk("stalled write", 32'h5a5a + 32'(m), 32'(rv[15:0]));
    end
    other_hit <= 1'h1;
    op(1'h1, 1'h1, 14'h0007, 16'h0000);
    op(1'h1, 1'h0, 14'h0007, 16'h0000);
    chk("flag under match", 32'h0, 32'(rv[15:0]));
    other_hit <= 1'h0;
    axi_rd(8'h20);
    chk("unmapped rresp", 32'(dpctl_pkg::RESP_SLVERR), 32'(rr));
    chk("unmapped rdata", 32'h0, rv);
    axi_wr(8'h24, 32'h1);
    chk("unmapped bresp", 32'(dpctl_pkg::RESP_SLVERR), 32'(rr));
    // Reset in mid-run, while a port cycle has just been ordered
    axi_wr(dpctl_pkg::CTRL_OFS, 32'h3);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("pins after reset", 32'h7, {29'h0, chip_select_n, flag_select_n, write_strobe_n});
    axi_rd(dpctl_pkg::STAT_OFS);
    chk("busy after reset", 32'h0, 32'(rv[dpctl_pkg::STAT_BUSY_BIT]));
    stop_test();
  end
endmodule : dpctl_port_ctrl_bench
